// >>> design/spi_port_pkg.sv
// Purpose: Shared constants for the serial peripheral port.
// Assumes: Classic Wishbone slave with 32-bit data, byte addresses.
// Notes: Registers hold 8 bits in the low byte; upper bits read zero.
package spi_port_pkg;
  localparam logic [3:0] CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] DATA_OFFSET = 4'h8;
  localparam int RATE0_POS = 0;
  localparam int RATE1_POS = 1;
  localparam int MASTER_POS = 4;
  localparam int RATE2_POS = 7;
  localparam int CLOCK_POLARITY_BIT_POS = 3;
  localparam int CLOCK_PHASE_BIT_POS = 2;
  localparam int SELECT_DISABLE_BIT_POS = 5;
  localparam int ENABLE_POS = 6;
  localparam int TRANSFER_COMPLETE_FLAG_POS = 7;
  localparam int WRITE_COLLISION_FLAG_POS = 6;
  localparam int MODE_FAULT_FLAG_POS = 4;
  localparam int BUSY_POS = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h14;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} xfer_state_t;
endpackage

// >>> design/spi_rate_gen.sv
// Purpose: Master serial clock tick generator.
// Assumes: Rate code as in the control register.
// Notes: Emits one tick per half serial clock period.
`timescale 1ns/1ps
module spi_rate_gen
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [2:0] i_rate,
  output logic o_tick
);
  import spi_port_pkg::*;
  logic [5:0] count_reg;
  logic [5:0] count_next;
  wire [5:0] half_limit;
  wire reserved_rate;
  // Divisor is 2 << rate, so half period is 1 << rate peripheral clocks.
  assign half_limit = 6'((7'h1 << i_rate) - 7'h1);
  assign reserved_rate = (i_rate == RATE_RESERVED);
  assign o_tick = i_run && !reserved_rate && (count_reg == half_limit);
  assign count_next = (!i_run || o_tick) ? 6'h0 : count_reg + 6'h1;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_reg <= 6'h0;
    else
      count_reg <= count_next;
  end
endmodule // spi_rate_gen

// >>> design/spi_master_slave_port.sv
// Purpose: Full-duplex SPI port, master or slave, with Wishbone registers.
// Assumes: All pins synchronous to I_CLOCK; slave clock well below it.
// Notes: Flags clear by read of status then read or write of data; mode fault by read of status then write of control.
// What this block does
// (RULE1) Bytes shift as eight bits, most significant bit first.
// (RULE2) Master drives MOSI, samples MISO; slave does the reverse.
// (RULE3) Master emits exactly eight SCK cycles per byte.
// (RULE4) External master holds our select low through a whole message.
// (RULE5) Slave puts MISO in high impedance while select is high, except with phase and select-disable both set.
// (RULE6) External master selects only one slave at a time.
// (RULE7) Master with select-disable ignores select and never sets mode fault.
// (RULE8) Slave with phase and select-disable set acts always selected.
// (RULE9) Software never sets select-disable while phase is zero.
// (RULE10) Setting select-disable does not clear mode fault.
// (RULE11) Master SCK is the clock divided by 2 to 128 via rate field.
// (RULE12) Codes 000, 001, 010 give divisors 2, 4, 8.
// (RULE13) Codes 011 to 110 give 16 to 128; 111 gives no clock.
// (RULE14) Mode and configuration come from a single control register.
// (RULE15) Data shifts out and in together on the same SCK.
// (RULE16) An unselected slave drives no serial line.
// (RULE17) Software sets slave mode before enabling the port.
// (RULE18) External SCK stays at or below our clock rate.
// (RULE19) Software disables the port before changing polarity or phase.
// (RULE20) Master holds SCK at the polarity idle level between bytes.
// (RULE21) Master select low sets mode fault, clears enable and master.
// (RULE22) Writing data mid-transfer sets write collision, transfer continues.
// (RULE23) Transfer-complete flag sets when a byte exchange finishes.
// (RULE24) With phase zero, the external master toggles select between bytes.
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module spi_master_slave_port
(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_WB_ERR,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE_N,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE_N,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE_N,
  input wire logic I_SS_N
);
  import spi_port_pkg::*;

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [7:0] control_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic transfer_complete_flag_reg;
  logic write_collision_flag_reg;
  logic mode_fault_flag_reg;
  logic status_seen_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  wire bus_req = I_WB_CYC && I_WB_STB && !ack_reg;
  wire hit_control = (I_WB_ADR == CONTROL_OFFSET);
  wire hit_status = (I_WB_ADR == STATUS_OFFSET);
  wire hit_data = (I_WB_ADR == DATA_OFFSET);
  wire mapped = hit_control || hit_status || hit_data;
  wire take = bus_req && mapped;
  wire wr_low = take && I_WB_WE && I_WB_SEL[0];
  wire wr_control = wr_low && hit_control;
  wire wr_data = wr_low && hit_data;
  wire rd_status = take && !I_WB_WE && hit_status;
  wire rd_data = take && !I_WB_WE && hit_data;

  wire enable = control_reg[ENABLE_POS];
  wire master = control_reg[MASTER_POS];
  wire clock_polarity_bit = control_reg[CLOCK_POLARITY_BIT_POS];
  wire clock_phase_bit = control_reg[CLOCK_PHASE_BIT_POS];
  wire select_disable_bit = control_reg[SELECT_DISABLE_BIT_POS];
  wire [2:0] rate = {control_reg[RATE2_POS], control_reg[RATE1_POS],
    control_reg[RATE0_POS]}; // RULE11 RULE14

  // ==========================================================
  // Transfer engine
  // ==========================================================
  xfer_state_t state_reg;
  xfer_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic in_bit_reg;
  logic in_bit_next;
  logic sck_reg;
  logic sck_next;
  logic sck_in_reg;
  logic ss_in_reg;
  logic busy;
  logic done;
  logic tick;

  // Mode fault: master whose own select drops while select is honoured.
  wire mode_fault = enable && master && !select_disable_bit && !I_SS_N; // RULE7 RULE21
  wire slave_sel = enable && !master &&
    ((clock_phase_bit && select_disable_bit) || !I_SS_N); // RULE8 RULE16
  wire lead_edge = sck_in_reg == clock_polarity_bit && I_SCK != clock_polarity_bit;
  wire trail_edge = sck_in_reg != clock_polarity_bit && I_SCK == clock_polarity_bit;
  wire ss_fall = ss_in_reg && !I_SS_N;
  wire start_master = enable && master && wr_data && !busy;
  // With phase zero the slave byte starts at the select falling edge, or at a leading edge while select is already low.
  wire start_slave = slave_sel && !busy &&
    (clock_phase_bit ? lead_edge : (ss_fall || (!I_SS_N && state_reg == ST_IDLE
    && !ss_in_reg && lead_edge))); // RULE24
  wire sample_edge = master ? (tick && (sck_reg == clock_polarity_bit) == !clock_phase_bit)
    : (clock_phase_bit ? trail_edge : lead_edge);
  wire shift_edge = master ? (tick && (sck_reg == clock_polarity_bit) == clock_phase_bit)
    : (clock_phase_bit ? lead_edge : trail_edge);
  wire serial_in = master ? I_MISO : I_MOSI; // RULE2

  spi_rate_gen u_rate
  (
    .i_clk(I_CLOCK),
    .i_rst_n(rst_n),
    .i_run(busy && master),
    .i_rate(rate),
    .o_tick(tick)
  ); // RULE12 RULE13

  assign busy = (state_reg != ST_IDLE);

  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    in_bit_next = in_bit_reg;
    sck_next = sck_reg;
    done = 1'b0;
    if (!enable || (!master && !slave_sel) || (master && mode_fault))
    begin
      state_next = ST_IDLE;
      sck_next = clock_polarity_bit; // RULE20
    end
    else if (state_reg == ST_IDLE)
    begin
      sck_next = clock_polarity_bit; // RULE20
      bit_next = 3'h0;
      if (start_master)
      begin
        shift_next = I_WB_DAT[7:0];
        state_next = ST_FIRST;
      end
      else if (start_slave)
      begin
        shift_next = tx_reg;
        state_next = ST_FIRST;
        if (clock_phase_bit)
          state_next = ST_SECOND;
      end
    end
    else
    begin
      if (master && tick)
        sck_next = !sck_reg;
      if (sample_edge)
      begin
        in_bit_next = serial_in; // RULE15
        if (!clock_phase_bit || bit_reg != 3'h0 || state_reg == ST_SECOND)
          state_next = ST_SECOND;
        // Phase one closes on the eighth sample, so MOSI holds through it.
        if (clock_phase_bit && bit_reg == 3'(BYTE_BITS - 1))
        begin
          state_next = ST_IDLE; // RULE3
          done = 1'b1; // RULE23
        end
      end
      if (shift_edge && state_reg == ST_SECOND)
      begin
        shift_next = {shift_reg[6:0], in_bit_next}; // RULE1 RULE15
        bit_next = bit_reg + 3'h1;
        if (bit_reg == 3'(BYTE_BITS - 1))
        begin
          // Eighth trailing edge closes the byte; SCK returns idle.
          state_next = ST_IDLE; // RULE3
          done = 1'b1; // RULE23
        end
      end
      else if (shift_edge && clock_phase_bit && state_reg == ST_FIRST)
        state_next = ST_SECOND;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= DATA_RESET;
      bit_reg <= 3'h0;
      in_bit_reg <= 1'b0;
      sck_reg <= 1'b0;
      sck_in_reg <= 1'b0;
      ss_in_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      in_bit_reg <= in_bit_next;
      sck_reg <= sck_next;
      sck_in_reg <= I_SCK;
      ss_in_reg <= I_SS_N;
    end
  end

  // ==========================================================
  // Control, status and data registers
  // ==========================================================
  wire [7:0] rx_byte = {shift_reg[6:0], in_bit_next}; // RULE1
  // Hardware sets win over software clears in the same cycle.
  wire clear_pending = status_seen_reg && (wr_control || wr_data || rd_data);
  logic [7:0] control_next;
  always_comb
  begin
    control_next = control_reg;
    if (wr_control)
      control_next = I_WB_DAT[7:0]; // RULE14 RULE19
    if (mode_fault)
      control_next = control_next &
        ~(8'h1 << ENABLE_POS) & ~(8'h1 << MASTER_POS); // RULE21
  end

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg <= CONTROL_RESET;
      tx_reg <= DATA_RESET;
      rx_reg <= DATA_RESET;
      transfer_complete_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      status_seen_reg <= 1'b0;
    end
    else
    begin
      control_reg <= control_next;
      if (wr_data && !busy)
        tx_reg <= I_WB_DAT[7:0];
      if (done)
        rx_reg <= rx_byte;
      if (rd_status)
        status_seen_reg <= 1'b1;
      else if (wr_control || wr_data || rd_data)
        status_seen_reg <= 1'b0;
      transfer_complete_flag_reg <= done || (transfer_complete_flag_reg &&
        !(clear_pending && (rd_data || wr_data))); // RULE23
      write_collision_flag_reg <= (wr_data && busy) || (write_collision_flag_reg &&
        !(clear_pending && (rd_data || wr_data))); // RULE22
      // Only the read-then-control-write sequence clears mode fault.
      mode_fault_flag_reg <= mode_fault || (mode_fault_flag_reg &&
        !(clear_pending && wr_control)); // RULE10 RULE21
    end
  end

  wire [7:0] status_value = (8'h1 << TRANSFER_COMPLETE_FLAG_POS) & {8{transfer_complete_flag_reg}} |
    (8'h1 << WRITE_COLLISION_FLAG_POS) & {8{write_collision_flag_reg}} |
    (8'h1 << MODE_FAULT_FLAG_POS) & {8{mode_fault_flag_reg}} |
    (8'h1 << BUSY_POS) & {8{busy}};
  wire [7:0] read_value = hit_control ? control_reg :
    hit_status ? status_value : rx_reg;

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= take;
      if (take)
        rdata_reg <= {24'h0, read_value};
    end
  end

  logic err_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      err_reg <= 1'b0;
    else
      err_reg <= bus_req && !mapped && !err_reg;
  end

  assign O_WB_ACK = ack_reg;
  assign O_WB_ERR = err_reg;
  assign O_WB_DAT = rdata_reg;

  // ==========================================================
  // Pins
  // ==========================================================
  wire drive_master = enable && master;
  assign O_SCK = sck_reg;
  assign O_SCK_OE_N = !drive_master;
  assign O_MOSI = shift_reg[7]; // RULE1 RULE2
  assign O_MOSI_OE_N = !drive_master;
  assign O_MISO = shift_reg[7]; // RULE2
  assign O_MISO_OE_N = !slave_sel; // RULE5 RULE16
endmodule // spi_master_slave_port

// >>> sim/spi_port_properties.sv
// Purpose: Port-level checks for the SPI port.
// Assumes: Bound to the top module; one clock domain.
// Notes: Mode bits are not visible, so modes are read from enables.
`timescale 1ns/1ps
module spi_port_properties
(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_WB_ERR,
  input wire logic O_SCK_OE_N,
  input wire logic O_MOSI_OE_N,
  input wire logic O_MISO_OE_N,
  input wire logic I_SS_N
);
  // ========
  // Bus and pin relations.
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  sequence req_s;
    I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
  endsequence
  sequence ans_s;
    O_WB_ACK || O_WB_ERR;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("request not answered");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ans_s |-> $past(I_WB_CYC && I_WB_STB))
    else $error("answer without request");
  ack_err_a: assert property (!(O_WB_ACK && O_WB_ERR))
    else $error("ack and err together");
  rdata_upper_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0)
    else $error("upper read bits set");
  master_miso_a: assert property (!O_SCK_OE_N |-> O_MISO_OE_N)
    else $error("master drives miso");
  mosi_pair_a: assert property (O_MOSI_OE_N == O_SCK_OE_N)
    else $error("mosi and sck enables differ");
  slave_quiet_a: assert property ((I_SS_N && O_SCK_OE_N) [*4]
    |-> O_MISO_OE_N)
    else $error("unselected slave drives miso");
endmodule // spi_port_properties

// >>> sim/spi_slave_model.sv
// Purpose: External SPI slave facing the port in master mode.
// Assumes: Clock phase one; idle level from i_clock_polarity_bit.
// Notes: A released MISO shows the inverse of its last bit.
`timescale 1ns/1ps
module spi_slave_model
(
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  input wire logic i_clock_polarity_bit,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx,
  output int o_edges
);
  // ========
  // Shifting on serial clock edges.
  logic [7:0] shift;
  initial o_miso = 1'b0;
  always @(negedge i_ss_n)
  begin
    shift = i_tx;
    o_edges = 0;
  end
  always @(i_sck)
    if (!i_ss_n)
    begin
      o_edges++;
      if (i_sck ^ i_clock_polarity_bit)
      begin
        o_miso = shift[7];
        shift = shift << 1;
      end
      else
        o_rx = {o_rx[6:0], i_mosi};
    end
  // Inverting on release keeps a stale bit from passing as data.
  always @(posedge i_ss_n)
    o_miso = ~o_miso;
endmodule // spi_slave_model

// >>> sim/spi_master_slave_port_test.sv
// Purpose: Self-checking bench for the SPI port.
// Assumes: Classic Wishbone single cycles, low byte registers.
// Notes: Master traffic uses clock phase one; slave traffic uses both.
`timescale 1ns/1ps
module spi_master_slave_port_test;
  import spi_port_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, got_err;
  logic [3:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic ack, err, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic sck_i = 0, mosi_i = 0, ss_n = 1, sel_n = 1, clock_polarity_bit = 0, miso_m;
  logic [7:0] stx = 0, srx, rd, tx, b, sb;
  int n_mismatch = 0, total_checks = 0, edges, i, k;
  logic [7:0] exp_q[$];
  initial forever #4 clk = ~clk;
  spi_master_slave_port dut_u (.I_CLOCK(clk), .I_RESET_N(rst_n),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(4'hf),
    .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_WB_ERR(err), .I_SCK(sck_i), .O_SCK(sck_o), .O_SCK_OE_N(sck_oe_n),
    .I_MOSI(mosi_i), .O_MOSI(mosi_o), .O_MOSI_OE_N(mosi_oe_n),
    .I_MISO(miso_m), .O_MISO(miso_o), .O_MISO_OE_N(miso_oe_n),
    .I_SS_N(ss_n));
  spi_slave_model slave_u (.i_sck(sck_o), .i_mosi(mosi_o), .i_ss_n(sel_n),
    .i_clock_polarity_bit(clock_polarity_bit), .i_tx(stx), .o_miso(miso_m), .o_rx(srx),
    .o_edges(edges));
  // ========
  // Bus, compare and transfer tasks.
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do
      @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat[7:0];
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic [2:0] r);
    logic [7:0] ctl;
    int h;
    clock_polarity_bit = 1'($urandom);
    ctl = {r[2], 3'h5, clock_polarity_bit, 1'b1, r[1:0]};
    wb(1, CONTROL_OFFSET, ctl & 8'hbf, rd);
    wb(1, CONTROL_OFFSET, ctl, rd);
    stx = 8'($urandom);
    tx = 8'($urandom);
    exp_q.push_back(tx);
    @(posedge clk) sel_n <= 1'b0;
    wb(1, DATA_OFFSET, tx, rd);
    if (r == 3'h3)
      wb(1, DATA_OFFSET, ~tx, rd);
    k = 0;
    b[0] = sck_o;
    while (sck_o === b[0] && k < 300) @(posedge clk) k++;
    h = 0;
    b[0] = sck_o;
    while (sck_o === b[0] && h < 300) @(posedge clk) h++;
    chk(8'(h), 8'(1 << r));
    k = 0;
    do
      wb(0, STATUS_OFFSET, 0, rd);
    while (rd[TRANSFER_COMPLETE_FLAG_POS] !== 1'b1 && ++k < 2000);
    chk(rd[TRANSFER_COMPLETE_FLAG_POS], 1);
    chk(rd[WRITE_COLLISION_FLAG_POS], r == 3'h3);
    wb(0, DATA_OFFSET, 0, rd);
    chk(rd, stx);
    @(posedge clk) sel_n <= 1'b1;
    chk(srx, exp_q.pop_front());
    chk(edges[7:0], 8'd16);
    chk(sck_o, clock_polarity_bit);
    wb(1, CONTROL_OFFSET, ctl & 8'hbf, rd);
  endtask
  task automatic slave_byte(input logic ph);
    wb(1, CONTROL_OFFSET, {5'h0, ph, 2'h0}, rd);
    wb(1, CONTROL_OFFSET, {5'h8, ph, 2'h0}, rd);
    tx = 8'($urandom);
    b = 8'($urandom);
    wb(1, DATA_OFFSET, tx, rd);
    chk(miso_oe_n, 1);
    @(posedge clk) ss_n <= 1'b0;
    // Half periods of four clocks stay inside the slave's sampling limit.
    // MOSI moves mid-low so both phases see it settled at their sample.
    for (i = 7; i >= 0; i--)
    begin
      repeat (2) @(posedge clk);
      mosi_i <= b[i];
      repeat (2) @(posedge clk);
      sck_i <= 1'b1;
      repeat (4) @(posedge clk);
      sck_i <= 1'b0;
      sb[i] = miso_o;
    end
    chk(miso_oe_n, 0);
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    mosi_i <= ~mosi_i;
    repeat (6) @(posedge clk);
    chk(miso_oe_n, 1);
    chk(sb, tx);
    wb(0, DATA_OFFSET, 0, rd);
    chk(rd, b);
    wb(1, CONTROL_OFFSET, {5'h0, ph, 2'h0}, rd);
  endtask
  // ========
  // Main sequence.
  initial
  begin
    void'($urandom(30));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, CONTROL_OFFSET, 0, rd);
    chk(rd, CONTROL_RESET);
    wb(0, 4'hc, 0, rd);
    chk(got_err, 1);
    for (i = 0; i < 7; i++)
      xfer(i[2:0]);
    clock_polarity_bit = 1'b0;
    wb(1, CONTROL_OFFSET, 8'hd7, rd);
    wb(1, DATA_OFFSET, 8'h5a, rd);
    k = 0;
    repeat (300) @(posedge clk) k += int'(sck_o !== 1'b0);
    chk(k != 0, 0);
    wb(1, CONTROL_OFFSET, 8'h54, rd);
    @(posedge clk) ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    wb(0, CONTROL_OFFSET, 0, rd);
    chk(rd & 8'h50, 0);
    wb(1, CONTROL_OFFSET, 8'h74, rd);
    wb(0, STATUS_OFFSET, 0, rd);
    chk(rd[MODE_FAULT_FLAG_POS], 1);
    wb(1, CONTROL_OFFSET, 8'h74, rd);
    wb(0, STATUS_OFFSET, 0, rd);
    chk(rd[MODE_FAULT_FLAG_POS], 0);
    wb(0, CONTROL_OFFSET, 0, rd);
    chk(rd, 8'h74);
    @(posedge clk) ss_n <= 1'b1;
    slave_byte(1'b1);
    slave_byte(1'b0);
    wrap_up;
  end
  // The run needs some three thousand cycles; this allows over ten times that.
  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
endmodule // spi_master_slave_port_test
bind spi_master_slave_port spi_port_properties prop_u (.I_CLOCK, .I_RESET_N,
  .I_WB_CYC, .I_WB_STB, .O_WB_DAT, .O_WB_ACK, .O_WB_ERR, .O_SCK_OE_N,
  .O_MOSI_OE_N, .O_MISO_OE_N, .I_SS_N);
